// ===== core/bifr_pkg.sv
// Package of constants for the built-in input function router.
package bifr_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NUM_LINES = 16;
  localparam int NUM_CH = 2;
  localparam int NUM_FAST = 6;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_FUNC_CFG = 8'h00;
  localparam logic [7:0] OFS_INT_REQ = 8'h04;
  localparam logic [7:0] OFS_PCATCH_EN = 8'h08;
  localparam logic [7:0] OFS_LINE_LEVEL = 8'h0C;
  localparam logic [7:0] OFS_INPUT_IMAGE = 8'h10;
  localparam logic [7:0] OFS_SCAN_CTRL = 8'h14;
  localparam logic [7:0] OFS_INT_GRANT = 8'h18;
  localparam logic [7:0] OFS_LINE_CLASS = 8'h1C;

  // ----------------------------------------------------------------
  // Field positions of the function configuration and scan control registers
  // ----------------------------------------------------------------
  localparam int CFG_CNT_EN_POS = 0;
  localparam int CFG_Z_EN_POS = 2;
  localparam int CFG_POS_EN_POS = 4;
  localparam int CFG_WIDTH = 6;
  localparam int SCAN_END_POS = 0;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [5:0] RST_FUNC_CFG = 6'h00;
  localparam logic [15:0] RST_INT_REQ = 16'h0000;
  localparam logic [15:0] RST_PCATCH_EN = 16'h0000;

  // ----------------------------------------------------------------
  // Line numbers of the first channel; the second adds CNT_AB_STEP to A and B and one to the rest
  // ----------------------------------------------------------------
  localparam int LN_CNT_A = 0;
  localparam int LN_CNT_B = 1;
  localparam int CNT_AB_STEP = 2;
  localparam int LN_CNT_Z = 4;
  localparam int LN_CNT_FUNC = 6;
  localparam int LN_CNT_LATCH = 8;
  localparam int LN_AX_ZERO = 4;
  localparam int LN_AX_CMD = 6;
  localparam int LN_AX_READY = 8;
  localparam int LN_AX_DOG = 10;
  localparam int LN_AX_ULIM = 12;
  localparam int LN_AX_LLIM = 14;

  // ----------------------------------------------------------------
  // Bus answers
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ===== core/bifr_router.sv
// Input function router: routes sixteen external input lines to counter, positioning and program functions.
//
// Design decisions made here: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps

module bifr_router #(
  parameter int LINES = 16
) (
  input wire logic CLK_SYS,
  input wire logic ARST_N,
  input wire logic [LINES-1:0] IN_LINES,
  output logic [1:0] CNT_A,
  output logic [1:0] CNT_B,
  output logic [1:0] CNT_Z,
  output logic [1:0] CNT_FUNC,
  output logic [1:0] CNT_LATCH,
  output logic [1:0] AX_ZERO,
  output logic [1:0] AX_CMD,
  output logic [1:0] AX_READY,
  output logic [1:0] AX_DOG,
  output logic [1:0] AX_ULIM,
  output logic [1:0] AX_LLIM,
  output logic [LINES-1:0] INT_SRC,
  output logic [LINES-1:0] INPUT_IMAGE,
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY
);

  // ----------------------------------------------------------------
  // Bus write path
  // ----------------------------------------------------------------
  logic aw_hold_reg;
  logic [7:0] awaddr_reg;
  logic w_hold_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;

  wire aw_take = S_AXI_AWVALID && S_AXI_AWREADY;
  wire w_take = S_AXI_WVALID && S_AXI_WREADY;
  wire do_write = aw_hold_reg && w_hold_reg && !bvalid_reg;
  wire [31:0] wmask = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}}, {8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
  wire wr_cfg = do_write && (awaddr_reg == bifr_pkg::OFS_FUNC_CFG);
  wire wr_int = do_write && (awaddr_reg == bifr_pkg::OFS_INT_REQ);
  wire wr_pc = do_write && (awaddr_reg == bifr_pkg::OFS_PCATCH_EN);
  wire wr_scan = do_write && (awaddr_reg == bifr_pkg::OFS_SCAN_CTRL);
  wire wr_ro = do_write && ((awaddr_reg == bifr_pkg::OFS_LINE_LEVEL) || (awaddr_reg == bifr_pkg::OFS_INPUT_IMAGE)
    || (awaddr_reg == bifr_pkg::OFS_INT_GRANT) || (awaddr_reg == bifr_pkg::OFS_LINE_CLASS));
  wire wr_hit = wr_cfg || wr_int || wr_pc || wr_scan || wr_ro;

  assign S_AXI_AWREADY = !aw_hold_reg && !bvalid_reg;
  assign S_AXI_WREADY = !w_hold_reg && !bvalid_reg;
  assign S_AXI_BVALID = bvalid_reg;
  assign S_AXI_BRESP = bresp_reg;

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      aw_hold_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      w_hold_reg <= 1'b0;
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
    end else begin
      if (aw_take) begin
        aw_hold_reg <= 1'b1;
        awaddr_reg <= {S_AXI_AWADDR[7:2], 2'b00};
      end else if (do_write) begin
        aw_hold_reg <= 1'b0;
      end
      if (w_take) begin
        w_hold_reg <= 1'b1;
        wdata_reg <= S_AXI_WDATA;
        wstrb_reg <= S_AXI_WSTRB;
      end else if (do_write) begin
        w_hold_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= bifr_pkg::RESP_OKAY;
    end else if (do_write) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= wr_hit ? bifr_pkg::RESP_OKAY : bifr_pkg::RESP_SLVERR;
    end else if (S_AXI_BREADY) begin
      bvalid_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  // Routing is meant to be static: software sets it before the attached functions run.
  logic [bifr_pkg::CFG_WIDTH-1:0] cfg_reg;
  logic [LINES-1:0] int_req_reg;
  logic [LINES-1:0] pc_en_reg;

  wire [31:0] cfg_merge = ({26'h0000000, cfg_reg} & ~wmask) | (wdata_reg & wmask);
  wire [31:0] int_merge = ({16'h0000, int_req_reg} & ~wmask) | (wdata_reg & wmask);
  wire [31:0] pc_merge = ({16'h0000, pc_en_reg} & ~wmask) | (wdata_reg & wmask);
  wire scan_end = wr_scan && wstrb_reg[0] && wdata_reg[bifr_pkg::SCAN_END_POS];

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      cfg_reg <= bifr_pkg::RST_FUNC_CFG;
      int_req_reg <= bifr_pkg::RST_INT_REQ;
      pc_en_reg <= bifr_pkg::RST_PCATCH_EN;
    end else begin
      if (wr_cfg) begin
        cfg_reg <= cfg_merge[bifr_pkg::CFG_WIDTH-1:0];
      end
      if (wr_int) begin
        int_req_reg <= int_merge[LINES-1:0];
      end
      if (wr_pc) begin
        pc_en_reg <= pc_merge[LINES-1:0];
      end
    end
  end

  wire [1:0] cnt_en = cfg_reg[bifr_pkg::CFG_CNT_EN_POS +: 2];
  wire [1:0] z_en = cfg_reg[bifr_pkg::CFG_Z_EN_POS +: 2];
  wire [1:0] pos_en = cfg_reg[bifr_pkg::CFG_POS_EN_POS +: 2];

  // ----------------------------------------------------------------
  // Interrupt gating
  // ----------------------------------------------------------------
  // A counter channel takes its A and B lines away from interrupt use only; all else stays open.
  wire [LINES-1:0] int_block = {{(LINES-4){1'b0}}, {2{cnt_en[1]}}, {2{cnt_en[0]}}};
  wire [LINES-1:0] int_grant = int_req_reg & ~int_block;
  wire [LINES-1:0] fast_class = {{(LINES-bifr_pkg::NUM_FAST){1'b0}}, {bifr_pkg::NUM_FAST{1'b1}}};

  // ----------------------------------------------------------------
  // Program input image with pulse catch
  // ----------------------------------------------------------------
  logic [LINES-1:0] prev_reg;
  logic [LINES-1:0] catch_reg;
  logic [LINES-1:0] image_reg;
  logic [LINES-1:0] int_src_reg;

  wire [LINES-1:0] rise = IN_LINES & ~prev_reg;
  wire [LINES-1:0] caught = catch_reg | (rise & pc_en_reg);
  // A rising edge in the very cycle of the scan end is kept for the next scan too, so no edge is lost.
  wire [LINES-1:0] catch_next = scan_end ? (rise & pc_en_reg) : caught;
  wire [LINES-1:0] image_next = (pc_en_reg & caught) | (~pc_en_reg & IN_LINES);

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      prev_reg <= {LINES{1'b0}};
      catch_reg <= {LINES{1'b0}};
      image_reg <= {LINES{1'b0}};
      int_src_reg <= {LINES{1'b0}};
    end else begin
      prev_reg <= IN_LINES;
      catch_reg <= catch_next;
      int_src_reg <= IN_LINES & int_grant;
      if (scan_end) begin
        image_reg <= image_next;
      end
    end
  end

  assign INT_SRC = int_src_reg;
  assign INPUT_IMAGE = image_reg;

  // ----------------------------------------------------------------
  // Function routing, one pass per channel and axis
  // ----------------------------------------------------------------
  // Outputs are flopped once; an enabled line's level is untouched, only delayed one clock; a disabled one reads low.
  for (genvar ch = 0; ch < bifr_pkg::NUM_CH; ch++) begin : g_ch
    logic [10:0] route_reg;
    wire [10:0] route_next = {
      pos_en[ch] & IN_LINES[bifr_pkg::LN_AX_LLIM + ch],
      pos_en[ch] & IN_LINES[bifr_pkg::LN_AX_ULIM + ch],
      pos_en[ch] & IN_LINES[bifr_pkg::LN_AX_DOG + ch],
      pos_en[ch] & IN_LINES[bifr_pkg::LN_AX_READY + ch],
      pos_en[ch] & IN_LINES[bifr_pkg::LN_AX_CMD + ch],
      pos_en[ch] & IN_LINES[bifr_pkg::LN_AX_ZERO + ch],
      cnt_en[ch] & IN_LINES[bifr_pkg::LN_CNT_LATCH + ch],
      cnt_en[ch] & IN_LINES[bifr_pkg::LN_CNT_FUNC + ch],
      cnt_en[ch] & z_en[ch] & IN_LINES[bifr_pkg::LN_CNT_Z + ch],
      cnt_en[ch] & IN_LINES[bifr_pkg::LN_CNT_B + bifr_pkg::CNT_AB_STEP * ch],
      cnt_en[ch] & IN_LINES[bifr_pkg::LN_CNT_A + bifr_pkg::CNT_AB_STEP * ch]
    };

    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
        route_reg <= 11'h000;
      end else begin
        route_reg <= route_next;
      end
    end

    assign CNT_A[ch] = route_reg[0];
    assign CNT_B[ch] = route_reg[1];
    assign CNT_Z[ch] = route_reg[2];
    assign CNT_FUNC[ch] = route_reg[3];
    assign CNT_LATCH[ch] = route_reg[4];
    assign AX_ZERO[ch] = route_reg[5];
    assign AX_CMD[ch] = route_reg[6];
    assign AX_READY[ch] = route_reg[7];
    assign AX_DOG[ch] = route_reg[8];
    assign AX_ULIM[ch] = route_reg[9];
    assign AX_LLIM[ch] = route_reg[10];

    cnt_ab_route_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
      cnt_en[ch] |=> (CNT_A[ch] == $past(IN_LINES[bifr_pkg::LN_CNT_A + bifr_pkg::CNT_AB_STEP * ch]))
        && (CNT_B[ch] == $past(IN_LINES[bifr_pkg::LN_CNT_B + bifr_pkg::CNT_AB_STEP * ch])))
      else $error("Counter A or B phase not taken from its line.");

    cnt_z_route_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
      (cnt_en[ch] && z_en[ch]) |=> CNT_Z[ch] == $past(IN_LINES[bifr_pkg::LN_CNT_Z + ch]))
      else $error("Counter Z phase not taken from its line.");

    cnt_aux_route_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
      cnt_en[ch] |=> (CNT_FUNC[ch] == $past(IN_LINES[bifr_pkg::LN_CNT_FUNC + ch]))
        && (CNT_LATCH[ch] == $past(IN_LINES[bifr_pkg::LN_CNT_LATCH + ch])))
      else $error("Counter function or latch input misrouted.");

    ax_route_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
      pos_en[ch] |=> (AX_ZERO[ch] == $past(IN_LINES[bifr_pkg::LN_AX_ZERO + ch]))
        && (AX_CMD[ch] == $past(IN_LINES[bifr_pkg::LN_AX_CMD + ch]))
        && (AX_READY[ch] == $past(IN_LINES[bifr_pkg::LN_AX_READY + ch]))
        && (AX_DOG[ch] == $past(IN_LINES[bifr_pkg::LN_AX_DOG + ch]))
        && (AX_ULIM[ch] == $past(IN_LINES[bifr_pkg::LN_AX_ULIM + ch]))
        && (AX_LLIM[ch] == $past(IN_LINES[bifr_pkg::LN_AX_LLIM + ch])))
      else $error("Axis input misrouted.");

    idle_quiet_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
      (!cnt_en[ch] && !pos_en[ch]) |=> (route_reg == 11'h000))
      else $error("Disabled channel drives a function input.");

    z_quiet_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
      (cnt_en[ch] && !z_en[ch]) |=> !CNT_Z[ch])
      else $error("Counter Z phase driven while its enable is off.");
  end

  // ----------------------------------------------------------------
  // Bus read path
  // ----------------------------------------------------------------
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;

  wire ar_take = S_AXI_ARVALID && S_AXI_ARREADY;
  wire [7:0] raddr = {S_AXI_ARADDR[7:2], 2'b00};
  wire rd_cfg = raddr == bifr_pkg::OFS_FUNC_CFG;
  wire rd_int = raddr == bifr_pkg::OFS_INT_REQ;
  wire rd_pc = raddr == bifr_pkg::OFS_PCATCH_EN;
  wire rd_lvl = raddr == bifr_pkg::OFS_LINE_LEVEL;
  wire rd_img = raddr == bifr_pkg::OFS_INPUT_IMAGE;
  wire rd_scan = raddr == bifr_pkg::OFS_SCAN_CTRL;
  wire rd_grant = raddr == bifr_pkg::OFS_INT_GRANT;
  wire rd_class = raddr == bifr_pkg::OFS_LINE_CLASS;
  wire rd_hit = rd_cfg || rd_int || rd_pc || rd_lvl || rd_img || rd_scan || rd_grant || rd_class;
  wire [31:0] rd_mux = rd_cfg ? {26'h0000000, cfg_reg}
    : rd_int ? {16'h0000, int_req_reg}
    : rd_pc ? {16'h0000, pc_en_reg}
    : rd_lvl ? {16'h0000, IN_LINES}
    : rd_img ? {16'h0000, image_reg}
    : rd_grant ? {16'h0000, int_grant}
    : rd_class ? {16'h0000, fast_class}
    : 32'h00000000;

  assign S_AXI_ARREADY = !rvalid_reg;
  assign S_AXI_RVALID = rvalid_reg;
  assign S_AXI_RDATA = rdata_reg;
  assign S_AXI_RRESP = rresp_reg;

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= bifr_pkg::RESP_OKAY;
    end else if (ar_take) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_mux;
      rresp_reg <= rd_hit ? bifr_pkg::RESP_OKAY : bifr_pkg::RESP_SLVERR;
    end else if (S_AXI_RREADY) begin
      rvalid_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Checks on interrupt, image and bus answer behaviour
  // ----------------------------------------------------------------
  sequence scan_with_edge_s(int b);
    scan_end && pc_en_reg[b] && IN_LINES[b] && !prev_reg[b];
  endsequence

  int_refuse_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    cnt_en[0] |=> (INT_SRC[1:0] == 2'b00))
    else $error("Interrupt passed on a line held by counter one.");

  int_refuse_two_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    cnt_en[1] |=> (INT_SRC[3:2] == 2'b00))
    else $error("Interrupt passed on a line held by counter two.");

  line_free_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    (pos_en == 2'b11 && cnt_en == 2'b00) |=> (INT_SRC[3:0] == $past(IN_LINES[3:0] & int_req_reg[3:0])))
    else $error("Positioning took an interrupt away from a phase line.");

  int_pass_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    (int_req_reg[15] && IN_LINES[15]) |=> INT_SRC[15])
    else $error("Requested interrupt line not passed.");

  pcatch_one_scan_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    scan_with_edge_s(0) |=> INPUT_IMAGE[0] ##0 (catch_reg[0]))
    else $error("Caught edge not shown in image or lost for next scan.");

  image_hold_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    !scan_end |=> $stable(INPUT_IMAGE))
    else $error("Input image changed between scans.");

  gp_image_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    (scan_end && !pc_en_reg[7]) |=> INPUT_IMAGE[7] == $past(IN_LINES[7]))
    else $error("General-purpose image bit does not follow its line.");

  write_answer_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY) |-> ##[1:2] S_AXI_BVALID)
    else $error("Write answer late.");

  read_answer_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    (S_AXI_ARVALID && S_AXI_ARREADY) |=> S_AXI_RVALID)
    else $error("Read answer late.");

  read_error_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    (S_AXI_ARVALID && S_AXI_ARREADY && !rd_hit) |=> (S_AXI_RRESP == bifr_pkg::RESP_SLVERR))
    else $error("Unmapped read not answered with an error.");

endmodule // bifr_router

// ===== testbench/bifr_field_model.sv
// Far-side model: encoders on lines 0 to 3 and random switches on the rest.
`timescale 1ns/1ps
module bifr_field_model (
  input wire logic clk,
  input wire logic run,
  input wire logic [15:0] hold_val,
  output logic [15:0] lines
);
  // ----------------------------------------------------------------
  // Line levels
  // ----------------------------------------------------------------
  logic [1:0] phase_reg = 2'h0;
  logic [15:0] rnd_reg = 16'h0000;
  logic [1:0] quad;
  // Gray-coded phases so both encoder channels step like a real shaft.
  assign quad = {phase_reg[1], phase_reg[1] ^ phase_reg[0]};
  // When stopped, the bench owns every level so edges can be placed exactly.
  assign lines = run ? {rnd_reg[15:4], quad, quad} : hold_val;
  always @(posedge clk) begin
    phase_reg <= phase_reg + 2'h1;
    rnd_reg <= 16'($urandom);
  end
endmodule // bifr_field_model

// ===== testbench/test_bifr_router.sv
// Self-checking bench for the input function router.
`timescale 1ns/1ps
module test_bifr_router;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic run = 1'b0;
  logic chk = 1'b0;
  logic [15:0] hold_val = 16'h0000;
  logic [15:0] in_lines, int_src, image, ln_q, req_m, v;
  logic [5:0] cfg_m;
  logic [1:0] cnt_a, cnt_b, cnt_z, cnt_func, cnt_latch, ax_zero, ax_cmd, ax_ready, ax_dog, ax_ulim, ax_llim;
  logic [21:0] routed, exp_r;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata, rd;
  logic [5:0] cfgs [8] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h0F, 6'h30, 6'h15, 6'h3F};
  int error_cnt = 0;
  int tests_run = 0;

  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) ln_q <= in_lines;
  assign routed = {cnt_a, cnt_b, cnt_z, cnt_func, cnt_latch, ax_zero, ax_cmd, ax_ready, ax_dog, ax_ulim, ax_llim};

  bifr_field_model field_u (.clk(clk_sys), .run(run), .hold_val(hold_val), .lines(in_lines));

  bifr_router dut_u (.CLK_SYS(clk_sys), .ARST_N(arst_n), .IN_LINES(in_lines), .CNT_A(cnt_a), .CNT_B(cnt_b),
    .CNT_Z(cnt_z), .CNT_FUNC(cnt_func), .CNT_LATCH(cnt_latch), .AX_ZERO(ax_zero), .AX_CMD(ax_cmd),
    .AX_READY(ax_ready), .AX_DOG(ax_dog), .AX_ULIM(ax_ulim), .AX_LLIM(ax_llim), .INT_SRC(int_src),
    .INPUT_IMAGE(image), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
    .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));

  // ----------------------------------------------------------------
  // Reference model and checks
  // ----------------------------------------------------------------
  function automatic logic [21:0] exp_route(input logic [15:0] l, input logic [5:0] c);
    logic [1:0] ce, ze, pe;
    ce = c[bifr_pkg::CFG_CNT_EN_POS +: 2];
    ze = c[bifr_pkg::CFG_Z_EN_POS +: 2] & ce;
    pe = c[bifr_pkg::CFG_POS_EN_POS +: 2];
    return {ce & {l[2], l[0]}, ce & {l[3], l[1]}, ze & l[5:4], ce & l[7:6], ce & l[9:8], pe & l[5:4],
      pe & l[7:6], pe & l[9:8], pe & l[11:10], pe & l[13:12], pe & l[15:14]};
  endfunction

  // Counter use strips the interrupt request from its own A and B phase lines only.
  function automatic logic [15:0] grant(input logic [15:0] q, input logic [5:0] c);
    return q & ~{12'h000, {2{c[bifr_pkg::CFG_CNT_EN_POS + 1]}}, {2{c[bifr_pkg::CFG_CNT_EN_POS]}}};
  endfunction

  task automatic results;
    $display("Comparisons %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  always @(negedge clk_sys) begin
    if (chk) begin
      exp_r = exp_route(ln_q, cfg_m);
      check(32'(routed[21:12]), 32'(exp_r[21:12]));
      check(32'(routed[11:0]), 32'(exp_r[11:0]));
      check(32'(int_src), 32'(ln_q & grant(req_m, cfg_m)));
    end
  end

  // ----------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clk_sys);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!(bvalid && bready) && n < 50);
    r = bresp;
    bready <= 1'b0;
    if (n >= 50) begin
      error_cnt++;
      results();
    end
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clk_sys);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (!(rvalid && rready) && n < 50);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    if (n >= 50) begin
      error_cnt++;
      results();
    end
  endtask

  // Routing checks pause while the configuration register changes under them.
  task automatic set_cfg(input logic [5:0] c, input logic [15:0] q);
    chk <= 1'b0;
    axi_wr(bifr_pkg::OFS_FUNC_CFG, 32'(c), resp);
    axi_wr(bifr_pkg::OFS_INT_REQ, 32'(q), resp);
    cfg_m = c;
    req_m = q;
    repeat (2) @(posedge clk_sys);
    chk <= 1'b1;
  endtask

  task automatic scan_end;
    axi_wr(bifr_pkg::OFS_SCAN_CTRL, 32'h1, resp);
    @(negedge clk_sys);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'hF922));
    repeat (11) @(posedge clk_sys);
    @(negedge clk_sys);
    check({10'h0, routed}, 32'h0);
    check({int_src, image}, 32'h0);
    @(posedge clk_sys);
    arst_n <= 1'b1;
    axi_rd(bifr_pkg::OFS_FUNC_CFG, rd, resp);
    check(rd, 32'(bifr_pkg::RST_FUNC_CFG));
    axi_rd(bifr_pkg::OFS_PCATCH_EN, rd, resp);
    check(rd, 32'(bifr_pkg::RST_PCATCH_EN));
    axi_wr(bifr_pkg::OFS_LINE_CLASS, 32'h0, resp);
    check(32'(resp), 32'(bifr_pkg::RESP_OKAY));
    axi_rd(bifr_pkg::OFS_LINE_CLASS, rd, resp);
    check(rd, 32'h0000_003F);
    axi_rd(8'h20, rd, resp);
    check({rd[29:0], resp}, 32'(bifr_pkg::RESP_SLVERR));
    axi_wr(8'h24, 32'h1, resp);
    check(32'(resp), 32'(bifr_pkg::RESP_SLVERR));
    for (int i = 0; i < 8; i++) begin
      set_cfg(cfgs[i], 16'($urandom) | 16'h000F);
      axi_rd(bifr_pkg::OFS_INT_GRANT, rd, resp);
      check(rd, 32'(grant(req_m, cfg_m)));
      run <= 1'b1;
      repeat (40) @(posedge clk_sys);
      run <= 1'b0;
    end
    // Pulse catch on lines 0 and 8; line 1 and 15 are plain levels.
    axi_wr(bifr_pkg::OFS_PCATCH_EN, 32'h0000_0101, resp);
    repeat (3) @(posedge clk_sys);
    hold_val <= 16'h0001;
    @(posedge clk_sys);
    hold_val <= 16'h8002;
    repeat (2) @(posedge clk_sys);
    scan_end();
    check(32'(image), 32'h0000_8003);
    axi_rd(bifr_pkg::OFS_INPUT_IMAGE, rd, resp);
    check(rd, 32'h0000_8003);
    scan_end();
    check(32'(image), 32'h0000_8002);
    // Line 0 rises in the very cycle the scan-end write commits; the edge shows now and in the next scan.
    fork
      scan_end();
      begin
        repeat (2) @(posedge clk_sys);
        hold_val <= 16'h0003;
      end
    join
    check(32'(image), 32'h0000_0003);
    @(posedge clk_sys);
    hold_val <= 16'h0000;
    scan_end();
    check(32'(image), 32'h0000_0001);
    axi_wr(bifr_pkg::OFS_PCATCH_EN, 32'h0, resp);
    for (int i = 0; i < 4; i++) begin
      v = 16'($urandom);
      hold_val <= v;
      repeat (2) @(posedge clk_sys);
      scan_end();
      check(32'(image), 32'(v));
      axi_rd(bifr_pkg::OFS_LINE_LEVEL, rd, resp);
      check(rd, 32'(v));
    end
    results();
  end

  initial begin
    repeat (100000) @(posedge clk_sys);
    error_cnt++;
    results();
  end
endmodule // test_bifr_router
